// ---- src/dtbs_cfg.svh ----
// Purpose: constants of the drive tag and bus sequencer
// Assumes: 20 MHz aclk, AXI4-Lite register access
// Notes: every offset, control field and timing count of the block lives here
//
// What this block does
// - any of seven requests starts one cycle
// - head increment sets latch launching the sequence
// - first 1 MHz tick sets enable and A
// - phase bits step 10,11,01,00 then enable clears
// - bus enable one is delayed A and enable
// - bus enable one encloses tag strobe one
// - brief false bus enable two is tolerated
// - enable bus first, strobe after settling
// - bus enable two latched during read/write
// - cylinder load is seek and strobe one
// - read/erase activity is read state or erase window
// - erase window ends 20 us after write
// - read/erase drives head bits at enable one
// - head load is activity, normal, strobe one
// - read/write windows set at phase B
// - completion pulse ends every cycle, 4 us after start unless strobe two latches
// - read/write completion at strobe two trailing edge
// - formatting starts head zero, then increments
// - initiate-type cycle requests idle at completion
`ifndef DTBS_CFG_SVH
`define DTBS_CFG_SVH
// register byte offsets
`define DTBS_OFS_CTRL 4'h0
`define DTBS_OFS_STAT 4'h4
// control register fields
`define DTBS_CTRL_CYL_LSB 0
`define DTBS_CTRL_HEAD_LSB 8
`define DTBS_CTRL_RST 32'h0000_0000
// axi responses
`define DTBS_RESP_OKAY 2'h0
`define DTBS_RESP_SLVERR 2'h2
// timing, figures in ns, derived counts in aclk cycles
`define DTBS_CLK_NS 50
`define DTBS_TICK_NS 1000
`define DTBS_DLY_NS 200
`define DTBS_ERASE_NS 20000
`define DTBS_TICK_CYC (`DTBS_TICK_NS / `DTBS_CLK_NS)
`define DTBS_DLY_CYC ((`DTBS_DLY_NS + `DTBS_CLK_NS - 1) / `DTBS_CLK_NS)
`define DTBS_ERASE_CYC ((`DTBS_ERASE_NS + `DTBS_CLK_NS - 1) / `DTBS_CLK_NS)
`endif

// ---- src/dtbs_pkg.sv ----
// Purpose: shared types of the drive tag and bus sequencer
// Assumes: nothing beyond the header
// Notes: request and drive signals travel as packed structs
package dtbs_pkg;
  // start requests from the major state control, one-cycle pulses
  typedef struct packed {
    logic execute;
    logic enter_read;
    logic enter_write;
    logic enter_recal;
    logic enter_seek;
    logic initiate;
    logic head_inc;
  } dtbs_req_t;
  // major state levels
  typedef struct packed {
    logic read_state;
    logic write_state;
    logic seek_state;
  } dtbs_mstate_t;
  // cable to the selected drive
  typedef struct packed {
    logic bus_en1;
    logic bus_en2;
    logic tag_gate1;
    logic tag_gate2;
    logic cyl_load;
    logic head_load;
    logic cylinder_bits_drive;
    logic head_bits_drive;
    logic read_win;
    logic write_win;
    logic erase_win;
    logic [7:0] unit_bus;
  } dtbs_drive_t;
endpackage

// ---- src/dtbs_sync3.sv ----
// Purpose: three-stage synchroniser for a pin level
// Assumes: input asynchronous to aclk
// Notes: output follows once stages two and three agree
`timescale 1ns/1ns
module dtbs_sync3 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic pin,
  output logic level
);
  logic s1_r; // first stage, read only by s2_r
  logic s2_r; // second stage
  logic s3_r; // third stage
  // ****************************************
  // shift chain and agreement
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level <= 1'b0;
    end
    else if (ce)
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level <= s3_r; // stable change accepted
    end
  end
endmodule

// ---- src/dtbs_top.sv ----
// Purpose: tag and bus line sequencer toward the selected disk drive
// Assumes: requests and states come from logic on aclk; format switch is a pin
// Notes: registers over AXI4-Lite; all outputs registered
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "dtbs_cfg.svh"
module dtbs_top
  import dtbs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dtbs_req_t req,
  input wire dtbs_mstate_t mstate,
  input wire logic format_pin,
  output dtbs_drive_t drive,
  output logic cycle_done,
  output logic idle_req
);
  localparam logic [4:0] TICK_LAST = 5'(`DTBS_TICK_CYC - 1);
  localparam logic [8:0] ERASE_LOAD = 9'(`DTBS_ERASE_CYC);

  // ****************************************
  // decode helpers
  // ****************************************
  // byte lane merge for a register write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  // ****************************************
  // state declarations
  // ****************************************
  logic format_lvl; // synchronised format switch
  logic [6:0] pend_r; // latched start requests
  logic [6:0] pend_nxt;
  logic busy_r; // a cycle is under way
  logic gen_on_r; // gated 1 MHz generator running
  logic [4:0] div_r; // divider toward the tick
  logic en_r; // sequence enable bit
  logic pa_r; // phase bit a
  logic pb_r; // phase bit b
  logic [`DTBS_DLY_CYC-1:0] dly_r; // delay line on phase a
  logic tg2_r; // second tag strobe, may latch
  logic read_win_r; // read window
  logic write_win_r; // write window
  logic erase_win_r; // erase window
  logic [8:0] erase_cnt_r; // erase trailing counter
  logic init_kind_r; // cycle came from an initiate start
  logic [3:0] head_r; // head address register
  logic [7:0] cyl_r; // cylinder address register
  logic aw_got_r; // write address captured
  logic w_got_r; // write data captured
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // ****************************************
  // pin synchroniser
  // ****************************************
  dtbs_sync3 u_fmt (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin(format_pin),
    .level(format_lvl)
  );

  // ****************************************
  // combinational decode
  // ****************************************
  wire take = (|pend_r) & ~busy_r; // start a new cycle now
  wire tick = gen_on_r & (div_r == TICK_LAST); // 1 MHz tick
  wire seq_phase_a_delayed = dly_r[`DTBS_DLY_CYC-1];
  wire read_or_erase_active = mstate.read_state | erase_win_r;
  wire normal_mode = ~format_lvl;
  wire bus_en1_nxt = seq_phase_a_delayed & en_r;
  wire tag_gate1_nxt = en_r & pa_r & pb_r;
  // strobe two sits in state 100, inside the second enable, and ends with it
  wire tg2_nxt = (en_r & ~pa_r & ~pb_r) | (read_or_erase_active & tg2_r);
  wire bus_en2_nxt = ~seq_phase_a_delayed & (en_r | (read_or_erase_active & tg2_r));
  wire cyl_drv_nxt = mstate.seek_state & bus_en1_nxt;
  wire head_drv_nxt = read_or_erase_active & bus_en1_nxt;
  wire head_allow = read_or_erase_active & normal_mode;
  wire done_nxt = busy_r & ~gen_on_r & ~en_r & ~tg2_r;
  wire wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wr_ctrl = wr_fire & (awaddr_r == `DTBS_OFS_CTRL);
  wire [31:0] ctrl_img = {20'h0, head_r, cyl_r};
  wire [31:0] ctrl_new = lane_merge(ctrl_img, wdata_r, wstrb_r);
  wire [31:0] stat_img = {20'h0, format_lvl, erase_win_r, write_win_r, read_win_r,
                          tg2_r, pb_r, pa_r, en_r, gen_on_r, busy_r, pend_r[0], 1'b0};
  wire ar_ctrl = s_axi_araddr == `DTBS_OFS_CTRL;
  wire ar_stat = s_axi_araddr == `DTBS_OFS_STAT;
  wire aw_ok = (awaddr_r == `DTBS_OFS_CTRL) | (awaddr_r == `DTBS_OFS_STAT);

  // latched requests, set wins over the clear at start
  always_comb
  begin
    pend_nxt = take ? 7'h00 : pend_r;
    pend_nxt = pend_nxt | req;
  end

  // ****************************************
  // request latch and cycle bookkeeping
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_r <= 7'h00;
      busy_r <= 1'b0;
      init_kind_r <= 1'b0;
    end
    else if (ce)
    begin
      pend_r <= pend_nxt;
      if (take)
      begin
        busy_r <= 1'b1;
        init_kind_r <= pend_r[1];
      end
      else if (done_nxt)
        busy_r <= 1'b0; // cycle over
    end
  end

  // ****************************************
  // gated 1 MHz generator
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gen_on_r <= 1'b0;
      div_r <= 5'h00;
    end
    else if (ce)
    begin
      if (take)
      begin
        gen_on_r <= 1'b1;
        div_r <= TICK_LAST; // first tick at once
      end
      else if (tick)
      begin
        div_r <= 5'h00;
        if (en_r & ~pa_r & ~pb_r)
          gen_on_r <= 1'b0; // fifth tick stops it
      end
      else if (gen_on_r)
        div_r <= div_r + 5'h01;
    end
  end

  // ****************************************
  // gray phase counter
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_r <= 1'b0;
      pa_r <= 1'b0;
      pb_r <= 1'b0;
    end
    else if (ce && tick)
    begin
      case ({en_r, pa_r, pb_r})
        3'b000:
        begin
          en_r <= 1'b1;
          pa_r <= 1'b1;
        end
        3'b110: pb_r <= 1'b1;
        3'b111: pa_r <= 1'b0;
        3'b101: pb_r <= 1'b0;
        3'b100: en_r <= 1'b0;
        default:
        begin
          en_r <= 1'b0; // illegal code recovers to rest
          pa_r <= 1'b0;
          pb_r <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // phase a delay line and strobe two
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dly_r <= '0;
      tg2_r <= 1'b0;
    end
    else if (ce)
    begin
      dly_r <= {dly_r[`DTBS_DLY_CYC-2:0], pa_r};
      tg2_r <= tg2_nxt;
    end
  end

  // ****************************************
  // read, write and erase windows
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      read_win_r <= 1'b0;
      write_win_r <= 1'b0;
      erase_win_r <= 1'b0;
      erase_cnt_r <= 9'h000;
    end
    else if (ce)
    begin
      read_win_r <= mstate.read_state & (read_win_r | pb_r);
      write_win_r <= mstate.write_state & (write_win_r | pb_r);
      if (mstate.write_state)
        erase_cnt_r <= ERASE_LOAD; // reloads while writing
      else if (erase_cnt_r != 9'h000)
        erase_cnt_r <= erase_cnt_r - 9'h001;
      erase_win_r <= write_win_r | (erase_win_r & (mstate.write_state
                     | (erase_cnt_r != 9'h000)));
    end
  end

  // ****************************************
  // address registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      head_r <= 4'(`DTBS_CTRL_RST >> `DTBS_CTRL_HEAD_LSB);
      cyl_r <= 8'(`DTBS_CTRL_RST >> `DTBS_CTRL_CYL_LSB);
    end
    else if (ce)
    begin
      if (take && format_lvl && pend_r[6])
        head_r <= 4'h0;
      else if (take && format_lvl && pend_r[0])
        head_r <= head_r + 4'h1;
      else if (wr_ctrl)
        head_r <= ctrl_new[`DTBS_CTRL_HEAD_LSB +: 4];
      if (wr_ctrl)
        cyl_r <= ctrl_new[`DTBS_CTRL_CYL_LSB +: 8];
    end
  end

  // ****************************************
  // cable outputs, all registered
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive <= '0;
      cycle_done <= 1'b0;
      idle_req <= 1'b0;
    end
    else if (ce)
    begin
      drive.bus_en1 <= bus_en1_nxt;
      drive.bus_en2 <= bus_en2_nxt;
      drive.tag_gate1 <= tag_gate1_nxt;
      drive.tag_gate2 <= tg2_nxt;
      drive.cyl_load <= mstate.seek_state & tag_gate1_nxt;
      drive.head_load <= head_allow & tag_gate1_nxt;
      drive.cylinder_bits_drive <= cyl_drv_nxt;
      drive.head_bits_drive <= head_drv_nxt;
      drive.read_win <= read_win_r;
      drive.write_win <= write_win_r;
      drive.erase_win <= erase_win_r;
      drive.unit_bus <= cyl_drv_nxt ? cyl_r : (head_drv_nxt ? {4'h0, head_r} : 8'h00);
      cycle_done <= done_nxt;
      idle_req <= done_nxt & init_kind_r;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DTBS_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1; // address held
        awaddr_r <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1; // data held
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1; // status writes ignored
        s_axi_bresp <= aw_ok ? `DTBS_RESP_OKAY : `DTBS_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DTBS_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= ar_ctrl ? ctrl_img : (ar_stat ? stat_img : 32'h0);
        s_axi_rresp <= (ar_ctrl | ar_stat) ? `DTBS_RESP_OKAY : `DTBS_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_start;
    @(posedge aclk) disable iff (!aresetn)
    (ce && take) |=> busy_r && gen_on_r;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_first_tick;
    @(posedge aclk) disable iff (!aresetn)
    (ce && tick && !en_r && !pa_r && !pb_r) |=> en_r && pa_r && !pb_r;
  endproperty
  a_first_tick: assert property (p_first_tick) else $error("first tick wrong");

  property p_gray;
    @(posedge aclk) disable iff (!aresetn)
    (ce && tick && en_r && pa_r && !pb_r) |=> en_r && pa_r && pb_r;
  endproperty
  a_gray: assert property (p_gray) else $error("phase b not set");

  property p_enclose;
    @(posedge aclk) disable iff (!aresetn)
    drive.tag_gate1 |-> drive.bus_en1;
  endproperty
  a_enclose: assert property (p_enclose) else $error("strobe outside enable");

  property p_enclose2;
    @(posedge aclk) disable iff (!aresetn)
    drive.tag_gate2 |-> drive.bus_en2;
  endproperty
  a_enclose2: assert property (p_enclose2) else $error("strobe two outside enable");

  property p_cyl_load;
    @(posedge aclk) disable iff (!aresetn)
    (ce && mstate.seek_state && tag_gate1_nxt) |=> drive.cyl_load;
  endproperty
  a_cyl_load: assert property (p_cyl_load) else $error("cylinder load missing");

  property p_head_load;
    @(posedge aclk) disable iff (!aresetn)
    drive.head_load |-> drive.tag_gate1 && drive.unit_bus[7:4] == 4'h0;
  endproperty
  a_head_load: assert property (p_head_load) else $error("head load wrong");

  property p_done_pulse;
    @(posedge aclk) disable iff (!aresetn)
    cycle_done |-> !drive.tag_gate2 && !en_r;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too early");

  property p_idle;
    @(posedge aclk) disable iff (!aresetn)
    idle_req |-> cycle_done;
  endproperty
  a_idle: assert property (p_idle) else $error("idle without completion");
endmodule

// ---- dv/dtbs_drive_model.sv ----
// Purpose: model of the selected disk drive on the tag and bus cable
// Assumes: cable outputs are registered on aclk
// Notes: captures the unit bus on the leading edge of each load strobe
`timescale 1ns/1ns
module dtbs_drive_model
  import dtbs_pkg::*;
(
  input wire logic aclk,
  input wire dtbs_drive_t drive,
  output logic [7:0] cylinder_address_reg,
  output logic [3:0] head_address_reg,
  output int head_loads
);
  // ***********************************
  // edge-triggered address capture
  // ***********************************
  logic cyl_prev; // load strobe history
  logic head_prev;
  initial
  begin
    cylinder_address_reg = 8'h00;
    head_address_reg = 4'h0;
    head_loads = 0;
    cyl_prev = 1'b0;
    head_prev = 1'b0;
  end
  // the drive reacts only to the strobe, never to the enable
  always @(posedge aclk)
  begin
    if (drive.cyl_load && !cyl_prev)
      cylinder_address_reg <= drive.unit_bus;
    if (drive.head_load && !head_prev)
    begin
      head_address_reg <= drive.unit_bus[3:0];
      head_loads <= head_loads + 1;
    end
    cyl_prev <= drive.cyl_load;
    head_prev <= drive.head_load;
  end
endmodule

// ---- dv/dtbs_top_test.sv ----
// Purpose: self-checking bench of the tag and bus sequencer
// Assumes: 20 MHz aclk, registers over AXI4-Lite
// Notes: one task per scenario; drive model captures cable addresses
`timescale 1ns/1ns
`include "dtbs_cfg.svh"
module dtbs_top_test
  import dtbs_pkg::*;
;
  // ***********************************
  // stimulus and observation
  // ***********************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  dtbs_req_t req = 7'h00; // start request pulses
  dtbs_mstate_t mstate = 3'h0; // major state levels
  logic format_pin = 1'b0;
  dtbs_drive_t drive;
  logic cycle_done;
  logic idle_req;
  logic [7:0] cyl_seen; // drive model capture
  logic [3:0] head_seen;
  int head_loads;
  int failures = 0;
  int comparisons = 0;
  int done_cnt = 0; // completion pulses seen
  logic last_idle = 1'b0; // idle request at last completion
  int viol = 0; // enable/strobe ordering breaks
  int bits_cnt = 0; // cycles with address bits on the bus
  int en2_run = 0;
  int en2_max = 0; // longest second enable run
  logic en1_prev = 1'b0;
  logic en2_prev = 1'b0;

  dtbs_top dtbs_top_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .req, .mstate, .format_pin, .drive, .cycle_done, .idle_req);
  dtbs_drive_model dtbs_drive_model_inst (.aclk, .drive, .cylinder_address_reg(cyl_seen),
    .head_address_reg(head_seen), .head_loads);

  // 50 ns clock
  always #25 aclk = ~aclk;

  // cable watcher: strobe only inside a settled enable
  always @(posedge aclk)
  begin
    if (drive.tag_gate1 && !(drive.bus_en1 && en1_prev))
      viol++;
    if (drive.tag_gate2 && !(drive.bus_en2 && en2_prev))
      viol++;
    if ((drive.cylinder_bits_drive || drive.head_bits_drive) && !drive.bus_en1)
      viol++;
    if (drive.cylinder_bits_drive || drive.head_bits_drive)
      bits_cnt++;
    en1_prev <= drive.bus_en1;
    en2_prev <= drive.bus_en2;
    en2_run <= drive.bus_en2 ? en2_run + 1 : 0;
    if (en2_run > en2_max)
      en2_max <= en2_run;
    if (cycle_done)
    begin
      done_cnt++;
      last_idle <= idle_req;
    end
  end

  // ***********************************
  // shared tasks
  // ***********************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic check_range(input string nm, input int n, input int lo, input int hi);
    check(nm, {31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  task give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // write with both channels offered together
  // waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    check("rdata", s_axi_rdata, ed);
  endtask

  task automatic pulse(input dtbs_req_t r);
    @(posedge aclk);
    req <= r;
    @(posedge aclk);
    req <= 7'h00;
  endtask

  // cycles from request release to completion
  task automatic wait_done(input int limit, output int n);
    int start;
    start = done_cnt;
    n = 0;
    while (done_cnt == start && n < limit)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    check_range("cycle_done wait", n, 1, limit - 1);
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  task automatic test_regs;
    axi_rd(`DTBS_OFS_CTRL, `DTBS_CTRL_RST, `DTBS_RESP_OKAY);
    axi_rd(`DTBS_OFS_STAT, 32'h0, `DTBS_RESP_OKAY);
    axi_wr(`DTBS_OFS_CTRL, 32'h0000_053c, `DTBS_RESP_OKAY);
    axi_rd(`DTBS_OFS_CTRL, 32'h0000_053c, `DTBS_RESP_OKAY);
    axi_wr(`DTBS_OFS_STAT, 32'hffff_ffff, `DTBS_RESP_OKAY);
    axi_rd(`DTBS_OFS_STAT, 32'h0, `DTBS_RESP_OKAY);
    axi_wr(4'h8, 32'h0000_0001, `DTBS_RESP_SLVERR);
    axi_rd(4'hc, 32'h0, `DTBS_RESP_SLVERR);
  endtask

  // execute, recal, initiate and head increment starts: one 4 us cycle, idle only for initiate
  task automatic test_starts;
    dtbs_req_t list [4];
    int n;
    list = '{7'h40, 7'h08, 7'h02, 7'h01};
    foreach (list[i])
    begin
      pulse(list[i]);
      wait_done(200, n);
      check_range("short cycle", n, 4 * `DTBS_TICK_CYC - 6, 4 * `DTBS_TICK_CYC + 8);
      check("idle_req", {31'h0, last_idle}, {31'h0, list[i] == 7'h02});
    end
  endtask

  task automatic test_seek;
    int n;
    int b0;
    @(posedge aclk);
    mstate <= 3'h1;
    en2_max = 0;
    b0 = bits_cnt;
    pulse(7'h04);
    wait_done(200, n);
    check("cylinder", {24'h0, cyl_seen}, 32'h3c);
    check_range("bus_en2 width", en2_max, 2 * `DTBS_TICK_CYC - 6, 2 * `DTBS_TICK_CYC + 2);
    check_range("cyl bits", bits_cnt - b0, 2 * `DTBS_TICK_CYC - 2, 2 * `DTBS_TICK_CYC + 2);
    @(posedge aclk);
    mstate <= 3'h0;
  endtask

  // read holds the second slot open until the read state ends
  task automatic test_read;
    int n;
    int d0;
    int b0;
    @(posedge aclk);
    mstate <= 3'h4;
    b0 = bits_cnt;
    pulse(7'h20);
    d0 = done_cnt;
    repeat (120) @(posedge aclk);
    #1;
    check("read_win", {31'h0, drive.read_win}, 32'h1);
    check("tag_gate2 held", {31'h0, drive.tag_gate2}, 32'h1);
    check("bus_en2 held", {31'h0, drive.bus_en2}, 32'h1);
    check("early done", done_cnt - d0, 32'h0);
    check("head", {28'h0, head_seen}, 32'h5);
    check_range("head bits", bits_cnt - b0, 2 * `DTBS_TICK_CYC - 2, 2 * `DTBS_TICK_CYC + 2);
    @(posedge aclk);
    mstate <= 3'h0;
    wait_done(60, n);
    check("read_win off", {31'h0, drive.read_win}, 32'h0);
  endtask

  task automatic test_write;
    int n;
    @(posedge aclk);
    mstate <= 3'h2;
    pulse(7'h10);
    repeat (120) @(posedge aclk);
    #1;
    check("write_win", {31'h0, drive.write_win}, 32'h1);
    check("erase_win", {31'h0, drive.erase_win}, 32'h1);
    @(posedge aclk);
    mstate <= 3'h0;
    n = 0;
    while (drive.erase_win && n < 1000)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    check_range("erase tail", n, `DTBS_ERASE_CYC - 2, `DTBS_ERASE_CYC + 6);
    wait_done(60, n);
    check("write_win off", {31'h0, drive.write_win}, 32'h0);
  endtask

  // format: head zero, one step per increment, no head load
  task automatic test_format;
    int n;
    int d0;
    int h0;
    @(posedge aclk);
    format_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    pulse(7'h40);
    wait_done(200, n);
    axi_rd(`DTBS_OFS_CTRL, 32'h0000_003c, `DTBS_RESP_OKAY);
    d0 = done_cnt;
    pulse(7'h01);
    repeat (250) @(posedge aclk);
    check("inc cycles", done_cnt - d0, 32'h1);
    axi_rd(`DTBS_OFS_CTRL, 32'h0000_013c, `DTBS_RESP_OKAY);
    h0 = head_loads;
    mstate <= 3'h4;
    pulse(7'h20);
    repeat (120) @(posedge aclk);
    mstate <= 3'h0;
    wait_done(60, n);
    check("format head load", head_loads - h0, 32'h0);
    @(posedge aclk);
    format_pin <= 1'b0;
  endtask

  // watchdog well beyond the expected run
  initial
  begin
    #(50 * 20000);
    failures++;
    give_verdict;
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_regs();
    test_starts();
    test_seek();
    test_read();
    test_write();
    test_format();
    check("strobe order", viol, 32'h0);
    give_verdict;
  end
endmodule
